// ### src/dade_pkg.sv
// Constants, field layout and state codes of the descriptor address engine
package dade_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_SRC_ADDR = 8'h00;
	localparam logic [7:0] OFS_ATTR = 8'h04;
	localparam logic [7:0] OFS_MINOR_BYTES = 8'h08;
	localparam logic [7:0] OFS_LAST_SRC_ADJ = 8'h0C;
	localparam logic [7:0] OFS_DST_ADDR = 8'h10;
	localparam logic [7:0] OFS_ITER_DST_OFS = 8'h14;
	localparam logic [7:0] OFS_CTRL = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;

	// ==========================================================
	// Field positions (word bit 0 is the least significant bit)
	localparam int SRC_MOD_LSB = 27;
	localparam int SRC_SIZE_LSB = 24;
	localparam int DST_MOD_LSB = 19;
	localparam int DST_SIZE_LSB = 16;
	localparam int SRC_OFS_LSB = 0;
	localparam int DST_OFS_LSB = 0;
	localparam int MAJOR_CNT_LSB = 16;
	localparam int CTRL_START_BIT = 0;
	localparam int ST_ACTIVE_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_CFGERR_BIT = 2;

	// ==========================================================
	// Reset values and encodings
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [14:0] MAJOR_ONE = 15'h0001;
	localparam logic [32:0] FOUR_GB = 33'h1_0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Transfer size codes
	localparam logic [2:0] SZ_8 = 3'h0;
	localparam logic [2:0] SZ_16 = 3'h1;
	localparam logic [2:0] SZ_32 = 3'h2;
	localparam logic [2:0] SZ_64 = 3'h3;
	localparam logic [2:0] SZ_32B = 3'h4;
	localparam logic [2:0] SZ_BURST = 3'h5;

	// ==========================================================
	// Engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PICK = 3'b001,
		ST_READ = 3'b010,
		ST_WRITE = 3'b011,
		ST_WBACK = 3'b100,
		ST_MAJOR = 3'b101
	} dade_state_t;

endpackage : dade_pkg

// ### src/dade_size_dec.sv
// Transfer size code decoder: bytes per access and reserved-code error
`timescale 1ns/1ps
module dade_size_dec
	import dade_pkg::*;
(
	input wire logic [2:0] code,
	output logic [5:0] bytes,
	output logic err
);
	// ==========================================================
	// Decode
	assign bytes = (code == SZ_8) ? 6'h01 :
		(code == SZ_16) ? 6'h02 :
		(code == SZ_32 || code == SZ_32B) ? 6'h04 :
		(code == SZ_64) ? 6'h08 :
		(code == SZ_BURST) ? 6'h20 : 6'h00;
	assign err = code[2] & code[1];
endmodule : dade_size_dec

// ### src/dade_addr_step.sv
// Next address: sign-extended offset plus optional modulo freeze of upper bits
`timescale 1ns/1ps
module dade_addr_step
	import dade_pkg::*;
(
	input wire logic [31:0] cur,
	input wire logic [31:0] addend,
	input wire logic [4:0] modulo,
	output logic [31:0] nxt
);
	// ==========================================================
	// Sum and modulo merge
	wire [31:0] sum = cur + addend;
	wire [31:0] low_mask = ~(32'hFFFF_FFFF << modulo);
	assign nxt = (modulo == 5'h00) ? sum :
		((sum & low_mask) | (cur & ~low_mask));
endmodule : dade_addr_step

// ### src/dade_engine.sv
// Single-channel descriptor address engine with AXI4-Lite register slave
//
// What this block does
// - Source modulo zero: source address follows offset arithmetic unrestricted.
// - Nonzero source modulo: only that many low source bits change.
// - Size codes: 8, 16, 32, 64 bit, 100 is 32 bit, 101 is 32-byte burst.
// - Size codes 110 or 111 raise a configuration error.
// - Destination modulo restricts destination address like source modulo.
// - Destination size decodes like source size, reserved codes included.
// - After each source read, add sign-extended source offset, then modulo.
// - Activation loads descriptor; reads and writes run until byte count moved.
// - Minor loop is indivisible; register writes neither stall nor halt it, only reset aborts it.
// - Minor loop end writes addresses back and decrements the major count.
// - Major count completion triggers final processing before finishing.
// - Minor byte count zero means four gigabytes.
// - On major completion add the last source adjustment to the source address.
// - Destination writes use the destination address field.
// - Source reads use the source address field.
// - After each destination write, add sign-extended destination offset.
`timescale 1ns/1ps
module dade_engine
	import dade_pkg::*;
#(
	parameter int DATA_W = 64
)(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic MRD_REQ,
	output logic [31:0] MRD_ADDR,
	output logic [2:0] MRD_SIZE,
	input wire logic MRD_ACK,
	input wire logic [DATA_W-1:0] MRD_DATA,
	output logic MWR_REQ,
	output logic [31:0] MWR_ADDR,
	output logic [2:0] MWR_SIZE,
	output logic [DATA_W-1:0] MWR_DATA,
	input wire logic MWR_ACK,
	output logic CH_ACTIVE,
	output logic CH_DONE
);
	// ==========================================================
	// Elaboration check
	if (DATA_W < 8 || DATA_W % 8 != 0) begin : g_bad_width
		$error("DATA_W must be a nonzero multiple of 8");
	end

	// ==========================================================
	// Descriptor and engine state
	logic [31:0] src_addr_ff, attr_ff, minor_bytes_ff, last_src_adj_ff, dst_addr_ff;
	logic [14:0] major_count_ff;
	logic [15:0] dst_offset_ff;
	logic [31:0] eng_src_ff, eng_dst_ff;
	logic [32:0] rd_left_ff, wr_left_ff;
	logic [DATA_W-1:0] data_ff;
	logic done_ff, cfg_err_ff;
	dade_state_t state_ff;

	// ==========================================================
	// AXI4-Lite slave state
	logic aw_held_ff, w_held_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;

	// ==========================================================
	// Field extraction and decoders
	wire [4:0] src_mod = attr_ff[SRC_MOD_LSB +: 5];
	wire [2:0] src_size = attr_ff[SRC_SIZE_LSB +: 3];
	wire [4:0] dst_mod = attr_ff[DST_MOD_LSB +: 5];
	wire [2:0] dst_size = attr_ff[DST_SIZE_LSB +: 3];
	wire [15:0] src_offset = attr_ff[SRC_OFS_LSB +: 16];
	wire [5:0] src_bytes, dst_bytes;
	wire src_err, dst_err;

	dade_size_dec u_src_dec (
		.code(src_size),
		.bytes(src_bytes),
		.err(src_err)
	);
	dade_size_dec u_dst_dec (
		.code(dst_size),
		.bytes(dst_bytes),
		.err(dst_err)
	);

	wire [31:0] nxt_src, nxt_dst, nxt_src_final;
	dade_addr_step u_src_step (
		.cur(eng_src_ff),
		.addend({{16{src_offset[15]}}, src_offset}),
		.modulo(src_mod),
		.nxt(nxt_src)
	);
	dade_addr_step u_dst_step (
		.cur(eng_dst_ff),
		.addend({{16{dst_offset_ff[15]}}, dst_offset_ff}),
		.modulo(dst_mod),
		.nxt(nxt_dst)
	);
	assign nxt_src_final = src_addr_ff + last_src_adj_ff;

	// ==========================================================
	// Bus decode
	wire wr_fire = aw_held_ff & w_held_ff & ~S_AXI_BVALID;
	wire rd_fire = S_AXI_ARVALID & S_AXI_ARREADY;
	wire busy = (state_ff != ST_IDLE);
	wire wr_src = wr_fire & (aw_addr_ff == OFS_SRC_ADDR) & ~busy;
	wire wr_attr = wr_fire & (aw_addr_ff == OFS_ATTR) & ~busy;
	wire wr_bytes = wr_fire & (aw_addr_ff == OFS_MINOR_BYTES) & ~busy;
	wire wr_adj = wr_fire & (aw_addr_ff == OFS_LAST_SRC_ADJ) & ~busy;
	wire wr_dst = wr_fire & (aw_addr_ff == OFS_DST_ADDR) & ~busy;
	wire wr_iter = wr_fire & (aw_addr_ff == OFS_ITER_DST_OFS) & ~busy;
	wire wr_ctrl = wr_fire & (aw_addr_ff == OFS_CTRL);
	wire wr_stat = wr_fire & (aw_addr_ff == OFS_STATUS);
	wire wr_mapped = (aw_addr_ff <= OFS_ITER_DST_OFS && aw_addr_ff[1:0] == 2'h0)
		| (aw_addr_ff == OFS_CTRL) | (aw_addr_ff == OFS_STATUS);
	wire [31:0] strb_mask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
		{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
	wire start_req = wr_ctrl & w_strb_ff[0] & w_data_ff[CTRL_START_BIT] & ~busy;
	wire cfg_bad = src_err | dst_err;
	wire start_ok = start_req & ~cfg_bad;
	wire [31:0] status_word = {29'h0, cfg_err_ff, done_ff, busy};
	wire [31:0] iter_word = {1'b0, major_count_ff, dst_offset_ff};
	wire rd_mapped = (S_AXI_ARADDR <= OFS_ITER_DST_OFS && S_AXI_ARADDR[1:0] == 2'h0)
		| (S_AXI_ARADDR == OFS_CTRL) | (S_AXI_ARADDR == OFS_STATUS);
	wire [31:0] rd_word = (S_AXI_ARADDR == OFS_SRC_ADDR) ? src_addr_ff :
		(S_AXI_ARADDR == OFS_ATTR) ? attr_ff :
		(S_AXI_ARADDR == OFS_MINOR_BYTES) ? minor_bytes_ff :
		(S_AXI_ARADDR == OFS_LAST_SRC_ADJ) ? last_src_adj_ff :
		(S_AXI_ARADDR == OFS_DST_ADDR) ? dst_addr_ff :
		(S_AXI_ARADDR == OFS_ITER_DST_OFS) ? iter_word :
		(S_AXI_ARADDR == OFS_STATUS) ? status_word : RST_WORD;

	// ==========================================================
	// Engine decisions
	wire [32:0] src_step = {27'h0, src_bytes};
	wire [32:0] dst_step = {27'h0, dst_bytes};
	wire [32:0] held_bytes = wr_left_ff - rd_left_ff;
	wire need_read = (rd_left_ff != 33'h0) & (held_bytes < dst_step);
	wire all_moved = (rd_left_ff == 33'h0) & (wr_left_ff == 33'h0);
	wire [32:0] load_count = (minor_bytes_ff == 32'h0) ? FOUR_GB :
		{1'b0, minor_bytes_ff};
	wire [32:0] nxt_rd_left = (rd_left_ff > src_step) ? rd_left_ff - src_step : 33'h0;
	wire [32:0] nxt_wr_left = (wr_left_ff > dst_step) ? wr_left_ff - dst_step : 33'h0;
	wire major_last = (major_count_ff == MAJOR_ONE);

	// ==========================================================
	// AXI4-Lite write channel
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff <= RST_WORD;
			w_strb_ff <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else begin
			S_AXI_AWREADY <= ~aw_held_ff & ~(S_AXI_AWVALID & S_AXI_AWREADY) & ~S_AXI_BVALID;
			S_AXI_WREADY <= ~w_held_ff & ~(S_AXI_WVALID & S_AXI_WREADY) & ~S_AXI_BVALID;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= {S_AXI_AWADDR[7:2], 2'h0};
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held_ff <= 1'b1;
				w_data_ff <= S_AXI_WDATA;
				w_strb_ff <= S_AXI_WSTRB;
			end
			if (wr_fire) begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= RST_WORD;
			S_AXI_RRESP <= RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= ~S_AXI_RVALID & ~rd_fire;
			if (rd_fire) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_word;
				S_AXI_RRESP <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Descriptor words (software writes only while idle)
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			src_addr_ff <= RST_WORD;
			attr_ff <= RST_WORD;
			minor_bytes_ff <= RST_WORD;
			last_src_adj_ff <= RST_WORD;
			dst_addr_ff <= RST_WORD;
			major_count_ff <= 15'h0000;
			dst_offset_ff <= 16'h0000;
		end else begin
			if (wr_src) src_addr_ff <= (src_addr_ff & ~strb_mask) | (w_data_ff & strb_mask);
			if (wr_attr) attr_ff <= (attr_ff & ~strb_mask) | (w_data_ff & strb_mask);
			if (wr_bytes) minor_bytes_ff <= (minor_bytes_ff & ~strb_mask) | (w_data_ff & strb_mask);
			if (wr_adj) last_src_adj_ff <= (last_src_adj_ff & ~strb_mask) | (w_data_ff & strb_mask);
			if (wr_dst) dst_addr_ff <= (dst_addr_ff & ~strb_mask) | (w_data_ff & strb_mask);
			if (wr_iter) begin
				major_count_ff <= (major_count_ff & ~strb_mask[30:16]) | (w_data_ff[30:16] & strb_mask[30:16]);
				dst_offset_ff <= (dst_offset_ff & ~strb_mask[15:0]) | (w_data_ff[15:0] & strb_mask[15:0]);
			end
			if (state_ff == ST_WBACK) begin
				src_addr_ff <= eng_src_ff;
				dst_addr_ff <= eng_dst_ff;
				major_count_ff <= major_count_ff - MAJOR_ONE;
			end
			if (state_ff == ST_MAJOR) src_addr_ff <= nxt_src_final;
		end
	end

	// ==========================================================
	// Minor loop engine
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_ff <= ST_IDLE;
			eng_src_ff <= RST_WORD;
			eng_dst_ff <= RST_WORD;
			rd_left_ff <= 33'h0;
			wr_left_ff <= 33'h0;
			data_ff <= '0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (start_ok) begin
						eng_src_ff <= src_addr_ff;
						eng_dst_ff <= dst_addr_ff;
						rd_left_ff <= load_count;
						wr_left_ff <= load_count;
						state_ff <= ST_PICK;
					end
				end
				ST_PICK: begin
					if (all_moved) state_ff <= ST_WBACK;
					else if (need_read) state_ff <= ST_READ;
					else state_ff <= ST_WRITE;
				end
				ST_READ: begin
					if (MRD_ACK) begin
						data_ff <= MRD_DATA;
						eng_src_ff <= nxt_src;
						rd_left_ff <= nxt_rd_left;
						state_ff <= ST_PICK;
					end
				end
				ST_WRITE: begin
					if (MWR_ACK) begin
						eng_dst_ff <= nxt_dst;
						wr_left_ff <= nxt_wr_left;
						state_ff <= ST_PICK;
					end
				end
				ST_WBACK: state_ff <= major_last ? ST_MAJOR : ST_IDLE;
				ST_MAJOR: state_ff <= ST_IDLE;
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// System bus requests and status flags (set wins over clear)
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			MRD_REQ <= 1'b0;
			MRD_ADDR <= RST_WORD;
			MRD_SIZE <= SZ_8;
			MWR_REQ <= 1'b0;
			MWR_ADDR <= RST_WORD;
			MWR_SIZE <= SZ_8;
			MWR_DATA <= '0;
			done_ff <= 1'b0;
			cfg_err_ff <= 1'b0;
			CH_ACTIVE <= 1'b0;
			CH_DONE <= 1'b0;
		end else begin
			MRD_REQ <= (state_ff == ST_PICK) & ~all_moved & need_read
				| (state_ff == ST_READ) & ~MRD_ACK;
			MRD_ADDR <= eng_src_ff;
			MRD_SIZE <= src_size;
			MWR_REQ <= (state_ff == ST_PICK) & ~all_moved & ~need_read
				| (state_ff == ST_WRITE) & ~MWR_ACK;
			MWR_ADDR <= eng_dst_ff;
			MWR_SIZE <= dst_size;
			MWR_DATA <= data_ff;
			if (state_ff == ST_MAJOR) done_ff <= 1'b1;
			else if (wr_stat && w_strb_ff[0] && w_data_ff[ST_DONE_BIT]) done_ff <= 1'b0;
			if (start_req && cfg_bad) cfg_err_ff <= 1'b1;
			else if (wr_stat && w_strb_ff[0] && w_data_ff[ST_CFGERR_BIT]) cfg_err_ff <= 1'b0;
			CH_ACTIVE <= start_ok | (busy & ~(state_ff == ST_MAJOR)
				& ~(state_ff == ST_WBACK & ~major_last));
			CH_DONE <= (state_ff == ST_MAJOR) | (done_ff
				& ~(wr_stat && w_strb_ff[0] && w_data_ff[ST_DONE_BIT]));
		end
	end

	// ==========================================================
	// Checks
	a_src_step_mod: assert property (@(posedge CLK) disable iff (!RSTN)
		(state_ff == ST_READ && MRD_ACK && src_mod != 5'h0) |=>
		((eng_src_ff ^ $past(eng_src_ff)) >> $past(src_mod)) == 32'h0)
		else $error("source upper bits changed under modulo");
	a_src_step_free: assert property (@(posedge CLK) disable iff (!RSTN)
		(state_ff == ST_READ && MRD_ACK && src_mod == 5'h0) |=>
		eng_src_ff == $past(eng_src_ff) + {{16{$past(src_offset[15])}}, $past(src_offset)})
		else $error("source address did not follow offset");
	a_dst_step_free: assert property (@(posedge CLK) disable iff (!RSTN)
		(state_ff == ST_WRITE && MWR_ACK && dst_mod == 5'h0) |=>
		eng_dst_ff == $past(eng_dst_ff) + {{16{$past(dst_offset_ff[15])}}, $past(dst_offset_ff)})
		else $error("destination address did not follow offset");
	a_zero_count: assert property (@(posedge CLK) disable iff (!RSTN)
		(start_ok && minor_bytes_ff == 32'h0) |=> rd_left_ff == FOUR_GB)
		else $error("zero byte count not taken as four gigabytes");
	a_bad_size: assert property (@(posedge CLK) disable iff (!RSTN)
		(start_req && src_size[2:1] == 2'b11) |=> cfg_err_ff && state_ff == ST_IDLE)
		else $error("reserved source size not flagged");
	a_bad_dst_size: assert property (@(posedge CLK) disable iff (!RSTN)
		(start_req && dst_size[2:1] == 2'b11) |=> cfg_err_ff && state_ff == ST_IDLE)
		else $error("reserved destination size not flagged");
	a_wback_major: assert property (@(posedge CLK) disable iff (!RSTN)
		(state_ff == ST_WBACK) |=> major_count_ff == $past(major_count_ff) - MAJOR_ONE)
		else $error("major count not decremented");
	a_final_adj: assert property (@(posedge CLK) disable iff (!RSTN)
		(state_ff == ST_WBACK && major_last) |=> ##1
		src_addr_ff == $past(eng_src_ff, 2) + last_src_adj_ff && done_ff)
		else $error("last source adjustment missing");
	a_read_addr: assert property (@(posedge CLK) disable iff (!RSTN)
		MRD_REQ |-> MRD_ADDR == eng_src_ff)
		else $error("read address is not the source address");
	a_count_step: assert property (@(posedge CLK) disable iff (!RSTN)
		(state_ff == ST_READ && MRD_ACK && rd_left_ff > src_step) |=>
		rd_left_ff == $past(rd_left_ff) - $past(src_step))
		else $error("read count not advanced by size");
endmodule : dade_engine

// ### verification/dade_mem_model.sv
// System bus memory model answering engine reads and writes
`timescale 1ns/1ps
module dade_mem_model
	import dade_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [3:0] LAT,
	input wire logic MRD_REQ,
	input wire logic [31:0] MRD_ADDR,
	output logic MRD_ACK,
	output logic [63:0] MRD_DATA,
	input wire logic MWR_REQ,
	output logic MWR_ACK
);
	// ==========================================================
	// Answer each request after LAT waiting cycles
	logic [3:0] rcnt_ff;
	logic [3:0] wcnt_ff;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rcnt_ff <= 4'h0;
			wcnt_ff <= 4'h0;
			MRD_ACK <= 1'b0;
			MWR_ACK <= 1'b0;
			MRD_DATA <= 64'h0;
		end else begin
			MRD_ACK <= 1'b0;
			MWR_ACK <= 1'b0;
			// Data line toggles outside an answer
			MRD_DATA <= ~MRD_DATA;
			if (MRD_REQ && !MRD_ACK) begin
				rcnt_ff <= (rcnt_ff >= LAT) ? 4'h0 : rcnt_ff + 4'h1;
				if (rcnt_ff >= LAT) begin
					MRD_ACK <= 1'b1;
					MRD_DATA <= {~MRD_ADDR, MRD_ADDR};
				end
			end
			if (MWR_REQ && !MWR_ACK) begin
				wcnt_ff <= (wcnt_ff >= LAT) ? 4'h0 : wcnt_ff + 4'h1;
				MWR_ACK <= (wcnt_ff >= LAT);
			end
		end
	end
endmodule : dade_mem_model

// ### verification/dma_descriptor_address_engine_test.sv
// Register-level test of the descriptor address engine
`timescale 1ns/1ps
module dma_descriptor_address_engine_test import dade_pkg::*; ();
	// ==========================================================
	// Signals
	logic clk, rst_n, awv, wv, brdy, arv, rrdy, awr, wrdy, bv, arr, rv;
	logic mrq, mwq, mack, wack, act, done;
	logic [7:0] awa, ara;
	logic [31:0] wdat, rdat, mra, mwa;
	logic [1:0] bresp, rresp;
	logic [2:0] mrs, mws, cs, cd;
	logic [63:0] mrd, mwd;
	logic [3:0] lat, wstb;
	logic [31:0] rq[$], wq[$];
	logic [63:0] wdq[$];
	logic [2:0] rsq[$], wsq[$];
	int failures, n_checks;
	int nbt[6] = '{1, 2, 4, 8, 4, 32};

	dade_engine uut (.CLK(clk), .RSTN(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wdat), .S_AXI_WSTRB(wstb), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy), .MRD_REQ(mrq),
		.MRD_ADDR(mra), .MRD_SIZE(mrs), .MRD_ACK(mack), .MRD_DATA(mrd), .MWR_REQ(mwq),
		.MWR_ADDR(mwa), .MWR_SIZE(mws), .MWR_DATA(mwd), .MWR_ACK(wack), .CH_ACTIVE(act),
		.CH_DONE(done));
	dade_mem_model mem (.CLK(clk), .RSTN(rst_n), .LAT(lat), .MRD_REQ(mrq), .MRD_ADDR(mra),
		.MRD_ACK(mack), .MRD_DATA(mrd), .MWR_REQ(mwq), .MWR_ACK(wack));

	// ==========================================================
	// Clock, bus monitor and watchdog
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (mrq === 1'b1 && mack === 1'b1) begin
			rq.push_back(mra);
			rsq.push_back(mrs);
		end
		if (mwq === 1'b1 && wack === 1'b1) begin
			wq.push_back(mwa);
			wdq.push_back(mwd);
			wsq.push_back(mws);
		end
	end
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		results();
	end

	// ==========================================================
	// Tasks
	task automatic results();
		$display("Checks %0d, failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [63:0] g, input logic [63:0] x);
		n_checks++;
		if (g !== x) begin
			failures++;
			$display("Error at %0t: value %0h, expected %0h", $time, g, x);
		end
	endtask : chk
	task automatic chkr(input logic [1:0] g, input logic [1:0] x);
		n_checks++;
		if (g !== x) begin
			failures++;
			$display("Error at %0t: response %0h, expected %0h", $time, g, x);
		end
	endtask : chkr
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
		bit ad;
		bit wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clk);
		awa <= a;
		wdat <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (awr === 1'b1 && !ad) begin
				ad = 1'b1;
				awv <= 1'b0;
			end
			if (wrdy === 1'b1 && !wd) begin
				wd = 1'b1;
				wv <= 1'b0;
			end
		end
		while (bv !== 1'b1) @(posedge clk);
		brdy <= 1'b0;
		chkr(bresp, e);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e = RESP_OKAY);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		@(posedge clk);
		while (arr !== 1'b1) @(posedge clk);
		arv <= 1'b0;
		@(posedge clk);
		while (rv !== 1'b1) @(posedge clk);
		rrdy <= 1'b0;
		chk(rdat, x);
		chkr(rresp, e);
	endtask : rdchk
	function automatic logic [31:0] attr(input logic [4:0] sm, input logic [2:0] ss,
		input logic [4:0] dm, input logic [2:0] ds, input logic [15:0] so);
		return {sm, ss, dm, ds, so};
	endfunction : attr
	task automatic desc(input logic [31:0] s, at, nb, sl, d, it);
		wr(OFS_SRC_ADDR, s);
		wr(OFS_ATTR, at);
		wr(OFS_MINOR_BYTES, nb);
		wr(OFS_LAST_SRC_ADJ, sl);
		wr(OFS_DST_ADDR, d);
		wr(OFS_ITER_DST_OFS, it);
	endtask : desc
	task automatic go();
		rq.delete();
		wq.delete();
		wdq.delete();
		rsq.delete();
		wsq.delete();
		wr(OFS_CTRL, 32'h1);
		while (act === 1'b1) @(posedge clk);
	endtask : go

	// ==========================================================
	// Tests
	initial begin
		{awv, wv, brdy, arv, rrdy, awa, ara, wdat, lat} = '0;
		wstb = 4'hF;
		rst_n = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		wr(8'h18, 32'h1, RESP_SLVERR);
		rdchk(8'h18, 32'h0, RESP_SLVERR);
		// Negative source offset across a boundary, last adjust restores start
		desc(32'h1000, attr(0, SZ_32, 0, SZ_32, 16'hFFFC), 8, 8, 32'h2000, 32'h0001_0008);
		go();
		chk(rq.size(), 2);
		chk(rq[0], 32'h1000);
		chk(rq[1], 32'h0FFC);
		chk(wq[0], 32'h2000);
		chk(wq[1], 32'h2008);
		chk(wdq[1], {~32'h0FFC, 32'h0FFC});
		rdchk(OFS_SRC_ADDR, 32'h1000);
		rdchk(OFS_DST_ADDR, 32'h2010);
		rdchk(OFS_ITER_DST_OFS, 32'h0000_0008);
		rdchk(OFS_STATUS, 32'h2);
		chk(done, 1'b1);
		wr(OFS_STATUS, 32'h2);
		// Byte strobes merge lanes; a start needs the lowest lane
		wstb <= 4'h3;
		wr(OFS_LAST_SRC_ADJ, 32'hFFFF_FFFF);
		rdchk(OFS_LAST_SRC_ADJ, 32'h0000_FFFF);
		wstb <= 4'hE;
		wr(OFS_CTRL, 32'h1);
		chk(act, 1'b0);
		wstb <= 4'hF;
		// Circular regions with a slow partner, two minor loops
		lat <= 4'h5;
		desc(32'h100C, attr(4, SZ_32, 3, SZ_32, 16'h4), 8, 32'h100, 32'h2004, 32'h0002_0004);
		go();
		chk(rq[1], 32'h1000);
		chk(wq[1], 32'h2000);
		rdchk(OFS_SRC_ADDR, 32'h1004);
		rdchk(OFS_ITER_DST_OFS, 32'h0001_0004);
		rdchk(OFS_STATUS, 32'h0);
		go();
		chk(rq[0], 32'h1004);
		chk(rq[1], 32'h1008);
		rdchk(OFS_STATUS, 32'h2);
		wr(OFS_STATUS, 32'h2);
		lat <= 4'h0;
		// Wide reads feeding narrow writes
		desc(32'h3000, attr(0, SZ_32, 0, SZ_8, 0), 4, 0, 32'h4000, 32'h0001_0001);
		go();
		chk(rq.size(), 1);
		chk(wq.size(), 4);
		chk(wq[3], 32'h4003);
		wr(OFS_STATUS, 32'h2);
		// Every valid size code on both sides
		for (int c = 0; c < 6; c++) begin
			desc(32'h3000, attr(0, c[2:0], 0, c[2:0], 0), nbt[c], 0, 32'h4000, 32'h0001_0000);
			go();
			chk(rq.size() + wq.size(), 2);
			chk(rsq[0], c[2:0]);
			chk(wsq[0], c[2:0]);
			wr(OFS_STATUS, 32'h2);
		end
		// Reserved size codes on each side
		for (int i = 0; i < 4; i++) begin
			cs = i[1] ? SZ_8 : (3'h6 | {2'h0, i[0]});
			cd = i[1] ? (3'h6 | {2'h0, i[0]}) : SZ_8;
			desc(32'h3000, attr(0, cs, 0, cd, 0), 1, 0, 32'h4000, 32'h0001_0000);
			go();
			chk(rq.size(), 0);
			rdchk(OFS_STATUS, 32'h4);
			wr(OFS_STATUS, 32'h4);
			rdchk(OFS_STATUS, 32'h0);
		end
		// Zero count runs on and cannot be disturbed, then reset mid-run
		desc(32'h3000, attr(0, SZ_8, 0, SZ_8, 1), 0, 0, 32'h4000, 32'h0001_0001);
		rq.delete();
		wr(OFS_CTRL, 32'h1);
		repeat (150) @(posedge clk);
		chk(act, 1'b1);
		wr(OFS_DST_ADDR, 32'h5555);
		wr(OFS_CTRL, 32'h1);
		rdchk(OFS_DST_ADDR, 32'h4000);
		chk(rq.size() > 20, 1'b1);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk(act, 1'b0);
		chk(mrq, 1'b0);
		rst_n <= 1'b1;
		rdchk(OFS_MINOR_BYTES, 32'h0);
		results();
	end
endmodule : dma_descriptor_address_engine_test
